// [design/tpc_pkg.sv]
/*
  Package for the tag protection command handler: register offsets, control
  field positions, command and error codes, page geometry and state codes.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package tpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] ADDR_CMD      = 12'h000;
  localparam logic [11:0] ADDR_CTRL     = 12'h004;
  localparam logic [11:0] ADDR_WDATA_LO = 12'h008;
  localparam logic [11:0] ADDR_WDATA_HI = 12'h00C;
  localparam logic [11:0] ADDR_STATUS   = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
  localparam logic [11:0] ADDR_RESULT   = 12'h01C;
  localparam logic [11:0] ADDR_WR_PAGES = 12'h020;
  localparam logic [11:0] ADDR_RD_PAGES = 12'h024;
  localparam logic [11:0] ADDR_UHF_PROT = 12'h028;

  ////////////////////////////////////////////////////////////////////////////
  // Control and interrupt register fields
  localparam int CTRL_UHF_BIT   = 0;
  localparam int CTRL_CHIP2_BIT = 1;
  localparam int CTRL_MULTI_BIT = 2;
  localparam int CTRL_URD_BIT   = 3;
  localparam int CTRL_AREA_LSB  = 4;
  localparam int CTRL_IDLEN_LSB = 8;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_ERR_BIT    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CMD_RESET   = 16'h0000;
  localparam logic [63:0] WDATA_RESET = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  MASK_RESET  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Commands, memory areas and error codes
  localparam logic [15:0] CMD_SET_PROT      = 16'h0103;
  localparam logic [15:0] CMD_SET_PROT_LOOP = 16'h2103;
  localparam logic [1:0]  AREA_PC_EPC       = 2'h1;
  localparam logic [1:0]  AREA_USER         = 2'h3;
  localparam logic [7:0]  IDLEN_ANY         = 8'h00;
  localparam logic [7:0]  IDLEN_NEXT        = 8'hFF;
  localparam logic [7:0]  IDLEN_MAX         = 8'h08;
  localparam logic [7:0]  ONE_TAG           = 8'h01;
  localparam logic [15:0] ERR_NONE          = 16'h0000;
  localparam logic [15:0] ERR_PAGE_BITS     = 16'h2502;
  localparam logic [15:0] ERR_MULTI_TAG     = 16'hE001;
  localparam logic [15:0] ERR_TAG_COUNT     = 16'hE002;
  localparam logic [15:0] ERR_ID_MISMATCH   = 16'hE003;
  localparam logic [15:0] ERR_ID_LENGTH     = 16'hE004;
  localparam logic [15:0] ERR_AREA          = 16'hE005;

  ////////////////////////////////////////////////////////////////////////////
  // Page geometry
  localparam int NUM_PAGES       = 20;
  localparam int CHIP1_PAGES     = 8;
  localparam int BLOCKS_PER_PAGE = 4;
  localparam int NUM_BLOCKS      = 80;
  localparam int EXCLUDED_BLOCK  = 79;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_CHECK = 1'b1
  } tpc_state_type;

endpackage

// [design/tpc_tag_protect.sv]
/*
  Set-tag-protection command handler with APB register access, page and
  block protection masks for HF tags, area protection for UHF tags and a
  level interrupt.
  Assumes tag count and tag identifier come from the reader front end in
  another clock domain; they are resynchronised here.
*/
module tpc_tag_protect (
  input  wire logic        CORE_CLK_IN,    // Core clock, 200 MHz
  input  wire logic        RST_B_IN,       // Asynchronous reset, active low
  input  wire logic        PSEL_IN,        // APB select
  input  wire logic        PENABLE_IN,     // APB enable
  input  wire logic        PWRITE_IN,      // APB write
  input  wire logic [11:0] PADDR_IN,       // APB byte address
  input  wire logic [31:0] PWDATA_IN,      // APB write data
  output logic      [31:0] PRDATA_OUT,     // APB read data
  output logic             PREADY_OUT,     // APB ready
  output logic             PSLVERR_OUT,    // APB error, unmapped address or write to read-only register
  input  wire logic [7:0]  TAG_COUNT_IN,   // Tags in detection range
  input  wire logic [63:0] TAG_ID_IN,      // Identifier of tag in range
  output logic             IRQ_OUT,        // Interrupt, level
  output logic             APPLY_OUT,      // Pulse, protection applied
  output logic             BUSY_OUT,       // Command under evaluation
  output logic      [15:0] ERR_CODE_OUT,   // Error code of last command
  output logic      [19:0] WR_PAGES_OUT,   // HF write protected pages
  output logic      [19:0] RD_PAGES_OUT,   // HF read protected pages
  output logic      [79:0] WR_BLOCKS_OUT,  // HF write protected blocks
  output logic      [79:0] RD_BLOCKS_OUT,  // HF read protected blocks
  output logic      [1:0]  UHF_WP_OUT,     // UHF write protected areas 1,3
  output logic      [1:0]  UHF_RP_OUT      // UHF read protected areas 1,3
);

  typedef struct packed {
    tpc_pkg::tpc_state_type st;
    logic                   busy;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic [15:0]            cmd;
    logic [15:0]            ctrl;
    logic [63:0]            wdata;
    logic [15:0]            err;
    logic [15:0]            resp;
    logic [1:0]             irq_stat;
    logic [1:0]             irq_mask;
    logic                   irq;
    logic                   apply;
    logic [19:0]            wr_pages;
    logic [19:0]            rd_pages;
    logic [79:0]            wr_blk;
    logic [79:0]            rd_blk;
    logic [1:0]             uhf_wp;
    logic [1:0]             uhf_rp;
    logic [63:0]            last_id;
    logic                   last_id_valid;
    logic [7:0]             cnt_s1;
    logic [7:0]             cnt_s2;
    logic [63:0]            id_s1;
    logic [63:0]            id_s2;
  } tpc_regs_type;

  tpc_regs_type state_reg;
  tpc_regs_type state_next;

  //////////////////////////////////////////////////////////////////////////////
  // Control fields and requested page masks
  logic        is_uhf;
  logic        chip2;
  logic        multi;
  logic        uhf_read;
  logic [1:0]  area;
  logic [7:0]  id_len;
  logic [19:0] req_wr;
  logic [19:0] req_rd;
  logic [19:0] inv_wr;
  logic [19:0] inv_rd;
  logic        bits_ok;
  logic [7:0]  id_byte_ok;
  logic        id_match;
  logic        id_is_new;
  logic [15:0] chk_err;
  logic [19:0] new_wr;
  logic [79:0] new_wr_blk;
  logic [79:0] new_rd_blk;
  logic        area_idx;

  assign is_uhf   = state_reg.ctrl[tpc_pkg::CTRL_UHF_BIT];
  assign chip2    = state_reg.ctrl[tpc_pkg::CTRL_CHIP2_BIT];
  assign multi    = state_reg.ctrl[tpc_pkg::CTRL_MULTI_BIT];
  assign uhf_read = state_reg.ctrl[tpc_pkg::CTRL_URD_BIT];
  assign area     = state_reg.ctrl[tpc_pkg::CTRL_AREA_LSB +: 2];
  assign id_len   = state_reg.ctrl[tpc_pkg::CTRL_IDLEN_LSB +: 8];
  assign area_idx = (area == tpc_pkg::AREA_USER);

  // First chip type only honours bytes 0 and 4
  assign req_wr = chip2 ? {state_reg.wdata[19:0]}
                        : {12'h000, state_reg.wdata[7:0]};
  assign req_rd = chip2 ? {state_reg.wdata[51:32]}
                        : {12'h000, state_reg.wdata[39:32]};

  // A run ending at the top page inverts to a run of ones from bit 0
  assign inv_wr  = ~req_wr;
  assign inv_rd  = ~req_rd;
  assign bits_ok = ((req_wr == req_rd) || (req_wr == 20'h0_0000)
                    || (req_rd == 20'h0_0000))
                   && ((inv_wr & 20'(inv_wr + 20'h0_0001)) == 20'h0_0000)
                   && ((inv_rd & 20'(inv_rd + 20'h0_0001)) == 20'h0_0000);

  generate
    for (genvar i = 0; i < 8; i++) begin : g_id
      assign id_byte_ok[i] = (8'(i) >= id_len)
                             || (state_reg.wdata[8*i +: 8] == state_reg.id_s2[8*i +: 8]);
    end
  endgenerate

  assign id_match  = &id_byte_ok;
  assign id_is_new = !state_reg.last_id_valid || (state_reg.id_s2 != state_reg.last_id);

  assign chk_err =
    (!is_uhf && multi)                        ? tpc_pkg::ERR_MULTI_TAG :
    (state_reg.cnt_s2 != tpc_pkg::ONE_TAG)    ? tpc_pkg::ERR_TAG_COUNT :
    ((id_len > tpc_pkg::IDLEN_MAX)
      && (id_len != tpc_pkg::IDLEN_NEXT))     ? tpc_pkg::ERR_ID_LENGTH :
    ((id_len != tpc_pkg::IDLEN_ANY)
      && (id_len != tpc_pkg::IDLEN_NEXT)
      && !id_match)                           ? tpc_pkg::ERR_ID_MISMATCH :
    ((id_len == tpc_pkg::IDLEN_NEXT)
      && !id_is_new)                          ? tpc_pkg::ERR_ID_MISMATCH :
    (is_uhf && (area != tpc_pkg::AREA_PC_EPC)
      && (area != tpc_pkg::AREA_USER))        ? tpc_pkg::ERR_AREA :
    (!is_uhf && chip2 && !bits_ok)            ? tpc_pkg::ERR_PAGE_BITS :
                                                tpc_pkg::ERR_NONE;

  assign new_wr = req_wr | req_rd;

  // Page to block expansion; the last block of the top page stays open
  generate
    for (genvar b = 0; b < tpc_pkg::NUM_BLOCKS; b++) begin : g_blk
      if (b == tpc_pkg::EXCLUDED_BLOCK) begin : g_excl
        assign new_wr_blk[b] = 1'b0;
        assign new_rd_blk[b] = 1'b0;
      end else begin : g_map
        assign new_wr_blk[b] = new_wr[b / tpc_pkg::BLOCKS_PER_PAGE];
        assign new_rd_blk[b] = req_rd[b / tpc_pkg::BLOCKS_PER_PAGE];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  logic        access;
  logic        wr_en;
  logic [1:0]  irq_set;

  always_comb begin
    state_next        = state_reg;
    state_next.apply  = 1'b0;
    state_next.cnt_s1 = TAG_COUNT_IN;
    state_next.cnt_s2 = state_reg.cnt_s1;
    state_next.id_s1  = TAG_ID_IN;
    state_next.id_s2  = state_reg.id_s1;
    irq_set           = 2'h0;
    access            = PSEL_IN && PENABLE_IN && state_reg.pready;
    wr_en             = access && PWRITE_IN;

    // Setup phase answers in the following access cycle
    state_next.pready  = PSEL_IN && !PENABLE_IN;
    state_next.pslverr = 1'b0;
    state_next.prdata  = 32'h0000_0000;
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      unique case (PADDR_IN)
        tpc_pkg::ADDR_CMD:      state_next.prdata = {16'h0000, state_reg.cmd};
        tpc_pkg::ADDR_CTRL:     state_next.prdata = {16'h0000, state_reg.ctrl};
        tpc_pkg::ADDR_WDATA_LO: state_next.prdata = state_reg.wdata[31:0];
        tpc_pkg::ADDR_WDATA_HI: state_next.prdata = state_reg.wdata[63:32];
        tpc_pkg::ADDR_STATUS:   state_next.prdata = {30'h0000_0000, state_reg.last_id_valid,
                                                     state_reg.st == tpc_pkg::ST_CHECK};
        tpc_pkg::ADDR_IRQ_STAT: state_next.prdata = {30'h0000_0000, state_reg.irq_stat};
        tpc_pkg::ADDR_IRQ_MASK: state_next.prdata = {30'h0000_0000, state_reg.irq_mask};
        tpc_pkg::ADDR_RESULT:   state_next.prdata = {state_reg.resp, state_reg.err};
        tpc_pkg::ADDR_WR_PAGES: state_next.prdata = {12'h000, state_reg.wr_pages};
        tpc_pkg::ADDR_RD_PAGES: state_next.prdata = {12'h000, state_reg.rd_pages};
        tpc_pkg::ADDR_UHF_PROT: state_next.prdata = {28'h000_0000, state_reg.uhf_rp, state_reg.uhf_wp};
        default:                state_next.pslverr = 1'b1;
      endcase
    end else if (PSEL_IN && !PENABLE_IN) begin
      unique case (PADDR_IN)
        tpc_pkg::ADDR_CMD, tpc_pkg::ADDR_CTRL, tpc_pkg::ADDR_WDATA_LO,
        tpc_pkg::ADDR_WDATA_HI, tpc_pkg::ADDR_IRQ_STAT,
        tpc_pkg::ADDR_IRQ_MASK: state_next.pslverr = 1'b0;
        default:                state_next.pslverr = 1'b1;
      endcase
    end

    if (wr_en) begin
      unique case (PADDR_IN)
        tpc_pkg::ADDR_CTRL:     state_next.ctrl          = PWDATA_IN[15:0];
        tpc_pkg::ADDR_WDATA_LO: state_next.wdata[31:0]   = PWDATA_IN;
        tpc_pkg::ADDR_WDATA_HI: state_next.wdata[63:32]  = PWDATA_IN;
        tpc_pkg::ADDR_IRQ_MASK: state_next.irq_mask      = PWDATA_IN[1:0];
        tpc_pkg::ADDR_IRQ_STAT: state_next.irq_stat      = state_reg.irq_stat & ~PWDATA_IN[1:0];
        tpc_pkg::ADDR_CMD: begin
          // Only the two set-protection codes start a check, and only when idle
          if ((state_reg.st == tpc_pkg::ST_IDLE)
              && ((PWDATA_IN[15:0] == tpc_pkg::CMD_SET_PROT)
                  || (PWDATA_IN[15:0] == tpc_pkg::CMD_SET_PROT_LOOP))) begin
            state_next.cmd = PWDATA_IN[15:0];
            state_next.st  = tpc_pkg::ST_CHECK;
          end
        end
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end

    if (state_reg.st == tpc_pkg::ST_CHECK) begin
      state_next.st   = tpc_pkg::ST_IDLE;
      state_next.err  = chk_err;
      state_next.resp = state_reg.cmd;
      irq_set[tpc_pkg::IRQ_DONE_BIT] = 1'b1;
      if (chk_err != tpc_pkg::ERR_NONE) begin
        irq_set[tpc_pkg::IRQ_ERR_BIT] = 1'b1;
      end else begin
        state_next.apply         = 1'b1;
        state_next.last_id       = state_reg.id_s2;
        state_next.last_id_valid = 1'b1;
        if (is_uhf) begin
          // Write protection is never withdrawn once set
          state_next.uhf_wp[area_idx] = 1'b1;
          state_next.uhf_rp[area_idx] = uhf_read;
        end else begin
          // Whole setting replaced by this one request
          state_next.wr_pages = new_wr;
          state_next.rd_pages = req_rd;
          state_next.wr_blk   = new_wr_blk;
          state_next.rd_blk   = new_rd_blk;
        end
      end
    end

    state_next.busy = (state_next.st == tpc_pkg::ST_CHECK);

    // A new event wins over a clear in the same cycle
    state_next.irq_stat = state_next.irq_stat | irq_set;
    state_next.irq      = |(state_next.irq_stat & state_next.irq_mask);
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg               <= '0;
      state_reg.st            <= tpc_pkg::ST_IDLE;
      state_reg.cmd           <= tpc_pkg::CMD_RESET;
      state_reg.ctrl          <= tpc_pkg::CTRL_RESET;
      state_reg.wdata         <= tpc_pkg::WDATA_RESET;
      state_reg.irq_mask      <= tpc_pkg::MASK_RESET;
      state_reg.err           <= tpc_pkg::ERR_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA_OUT    = state_reg.prdata;
  assign PREADY_OUT    = state_reg.pready;
  assign PSLVERR_OUT   = state_reg.pslverr;
  assign IRQ_OUT       = state_reg.irq;
  assign APPLY_OUT     = state_reg.apply;
  assign BUSY_OUT      = state_reg.busy;
  assign ERR_CODE_OUT  = state_reg.err;
  assign WR_PAGES_OUT  = state_reg.wr_pages;
  assign RD_PAGES_OUT  = state_reg.rd_pages;
  assign WR_BLOCKS_OUT = state_reg.wr_blk;
  assign RD_BLOCKS_OUT = state_reg.rd_blk;
  assign UHF_WP_OUT    = state_reg.uhf_wp;
  assign UHF_RP_OUT    = state_reg.uhf_rp;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  chk_cmd_start_code: assert property (
    $rose(BUSY_OUT) |-> (state_reg.cmd == tpc_pkg::CMD_SET_PROT)
                        || (state_reg.cmd == tpc_pkg::CMD_SET_PROT_LOOP))
    else $error("Check started by an unknown command code");

  chk_cmd_one_cycle: assert property (
    BUSY_OUT |=> !BUSY_OUT && (state_reg.resp == $past(state_reg.cmd)))
    else $error("Command check did not finish in one cycle");

  chk_read_has_write: assert property (
    ((RD_PAGES_OUT & ~WR_PAGES_OUT) == 20'h0_0000) && ((UHF_RP_OUT & ~UHF_WP_OUT) == 2'h0))
    else $error("Read protection without write protection");

  chk_block_79_open: assert property (
    !WR_BLOCKS_OUT[tpc_pkg::EXCLUDED_BLOCK] && !RD_BLOCKS_OUT[tpc_pkg::EXCLUDED_BLOCK]
    && (WR_BLOCKS_OUT[78:76] == {3{WR_PAGES_OUT[19]}})
    && (WR_BLOCKS_OUT[3:0] == {4{WR_PAGES_OUT[0]}}))
    else $error("Block mask does not follow page mask");

  chk_bad_bits_error: assert property (
    BUSY_OUT && !is_uhf && !multi && chip2 && !bits_ok
    && (state_reg.cnt_s2 == tpc_pkg::ONE_TAG) && (id_len == tpc_pkg::IDLEN_ANY)
    |=> (ERR_CODE_OUT == tpc_pkg::ERR_PAGE_BITS) && !APPLY_OUT && $stable(WR_PAGES_OUT))
    else $error("Bad page bits were not refused");

  chk_pready_pulse: assert property (
    PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("APB ready did not answer the setup cycle once");

  chk_apply_no_err: assert property (
    APPLY_OUT |-> (ERR_CODE_OUT == tpc_pkg::ERR_NONE) && !$past(APPLY_OUT))
    else $error("Protection applied with an error code");

  chk_err_keeps_masks: assert property (
    $fell(BUSY_OUT) && (ERR_CODE_OUT != tpc_pkg::ERR_NONE)
    |-> $stable(WR_PAGES_OUT) && $stable(RD_PAGES_OUT) && $stable(UHF_WP_OUT) && $stable(UHF_RP_OUT))
    else $error("Refused command changed the protection masks");

  chk_count_refused: assert property (
    BUSY_OUT && !(!is_uhf && multi) && (state_reg.cnt_s2 != tpc_pkg::ONE_TAG)
    |=> ERR_CODE_OUT == tpc_pkg::ERR_TAG_COUNT)
    else $error("Command ran without exactly one tag in range");

  chk_id_refused: assert property (
    BUSY_OUT && !(!is_uhf && multi) && (state_reg.cnt_s2 == tpc_pkg::ONE_TAG)
    && (id_len != tpc_pkg::IDLEN_ANY) && (id_len <= tpc_pkg::IDLEN_MAX)
    && (state_reg.wdata[7:0] != state_reg.id_s2[7:0])
    |=> ERR_CODE_OUT == tpc_pkg::ERR_ID_MISMATCH)
    else $error("Tag with another identifier was protected");

  chk_uhf_area_set: assert property (
    APPLY_OUT && $past(is_uhf) |-> ($past(area_idx) ? UHF_WP_OUT[1] : UHF_WP_OUT[0]))
    else $error("Selected UHF area not write protected");

  chk_hf_pages_set: assert property (
    APPLY_OUT && $past(!is_uhf && chip2)
    |-> (WR_PAGES_OUT == ($past(state_reg.wdata[19:0]) | $past(state_reg.wdata[51:32])))
        && (RD_PAGES_OUT == $past(state_reg.wdata[51:32])))
    else $error("HF page masks do not follow the write data");

  chk_multitag_fault: assert property (
    BUSY_OUT && !is_uhf && multi |=> ERR_CODE_OUT == tpc_pkg::ERR_MULTI_TAG && !APPLY_OUT)
    else $error("Multiple tag setting did not raise the fault");

  chk_uhf_wp_sticky: assert property (
    !$fell(UHF_WP_OUT[0]) && !$fell(UHF_WP_OUT[1]))
    else $error("UHF write protection was removed");

  chk_next_mode_same: assert property (
    BUSY_OUT && (id_len == tpc_pkg::IDLEN_NEXT) && state_reg.last_id_valid
    && (state_reg.id_s2 == state_reg.last_id) |=> !APPLY_OUT ##1 !APPLY_OUT)
    else $error("Same tag protected again in next mode");

  chk_irq_follows: assert property (
    $rose(APPLY_OUT) && state_reg.irq_mask[tpc_pkg::IRQ_DONE_BIT] |-> IRQ_OUT)
    else $error("Interrupt missing after a completed command");

endmodule

// [verif/tpc_front_model.sv]
/*
  Reader front end model: presents tag count and tag identifier of the
  tags in the detection range of the read/write head.
  Assumes the bench sets the wanted values; they change only on a clock edge.
*/
module tpc_front_model (
  input  wire logic        clk_in,         // Core clock
  input  wire logic [7:0]  count_in,       // Wanted tag count
  input  wire logic [63:0] id_in,          // Wanted tag identifier
  output logic      [7:0]  tag_count_out,  // Tags in range
  output logic      [63:0] tag_id_out      // Identifier of tag in range
);
  timeunit 1ns;
  timeprecision 1ps;

  // One tag in range except where the tag count refusal is being provoked
  always_ff @(posedge clk_in) begin
    tag_count_out <= count_in;
    tag_id_out    <= id_in;
  end
endmodule

// [verif/tb_top.sv]
/*
  Testbench for the tag protection command handler: APB tasks, command runs
  with expected error codes and masks, interrupt checks.
  Assumes the handler answers APB in one access cycle and results land one
  edge after the command write is taken.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, psel, pen, pwr, pready, pslverr, se, irq, apply, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] err;
  logic [19:0] wrp, rdp;
  logic [79:0] wrb, rdb;
  logic [1:0]  uwp, urp;
  logic [7:0]  cnt_set, tag_cnt;
  logic [63:0] id_set, tag_id;
  int          num_errors, checks_done, cyc, busy_cnt, busy_base;

  tpc_tag_protect u_tpc_tag_protect (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TAG_COUNT_IN(tag_cnt),
    .TAG_ID_IN(tag_id), .IRQ_OUT(irq), .APPLY_OUT(apply), .BUSY_OUT(busy), .ERR_CODE_OUT(err),
    .WR_PAGES_OUT(wrp), .RD_PAGES_OUT(rdp), .WR_BLOCKS_OUT(wrb), .RD_BLOCKS_OUT(rdb),
    .UHF_WP_OUT(uwp), .UHF_RP_OUT(urp));
  tpc_front_model u_tpc_front_model (.clk_in(clk), .count_in(cnt_set), .id_in(id_set),
    .tag_count_out(tag_cnt), .tag_id_out(tag_id));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (busy === 1'b1) busy_cnt++;
    if (cyc > 5000) begin
      num_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic run(input logic [15:0] c, input logic [63:0] w, input logic [15:0] code,
                     input logic [15:0] e);
    apb(1'b1, tpc_pkg::ADDR_CTRL, {16'h0000, c});
    apb(1'b1, tpc_pkg::ADDR_WDATA_LO, w[31:0]);
    apb(1'b1, tpc_pkg::ADDR_WDATA_HI, w[63:32]);
    busy_base = busy_cnt;
    apb(1'b1, tpc_pkg::ADDR_CMD, {16'h0000, code});
    #1;
    chk(busy_cnt - busy_base, 1);
    chk(err, e);
    chk(apply, e === 16'h0000);
    @(posedge clk);
  endtask

  task automatic tag(input logic [7:0] n, input logic [63:0] i);
    cnt_set <= n;
    id_set  <= i;
    repeat (5) @(posedge clk);
  endtask

  // Block b follows page b/4; the last block stays open
  function automatic logic [79:0] blk(input logic [19:0] p);
    logic [79:0] b;
    b = '0;
    for (int i = 0; i < 79; i++) b[i] = p[i/4];
    return b;
  endfunction

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    rst_b = 1'b0;
    cnt_set = 8'h01;
    id_set = 64'h1122_3344_5566_7788;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, tpc_pkg::ADDR_CTRL, 0);
    chk(rd, 0);
    apb(1'b0, tpc_pkg::ADDR_IRQ_MASK, 0);
    chk(rd, 0);
    apb(1'b0, 12'h030, 0);
    chk({se, rd}, 33'h1_0000_0000);
    done("reset");
    run(16'h0031, 0, tpc_pkg::CMD_SET_PROT, 0);
    chk({uwp, urp}, 4'b1000);
    run(16'h0219, 64'h7788, tpc_pkg::CMD_SET_PROT, 0);
    chk({uwp, urp[0]}, 3'b111);
    run(16'h0219, 0, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_ID_MISMATCH);
    run(16'h0021, 0, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_AREA);
    run(16'hFF31, 0, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_ID_MISMATCH);
    tag(8'h01, 64'h0102_0304_0506_0708);
    run(16'hFF31, 0, tpc_pkg::CMD_SET_PROT, 0);
    chk(uwp, 2'b11);
    tag(8'h02, 64'h0102_0304_0506_0708);
    run(16'h0031, 0, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_TAG_COUNT);
    tag(8'h01, 64'h0102_0304_0506_0708);
    done("uhf");
    run(16'h0002, 64'h000F_FFFE_000F_FFFE, tpc_pkg::CMD_SET_PROT_LOOP, 0);
    chk({wrp, rdp}, 40'hF_FFFE_F_FFFE);
    chk(wrb, blk(20'hF_FFFE));
    chk(rdb, blk(20'hF_FFFE));
    apb(1'b0, tpc_pkg::ADDR_RESULT, 32'h0000_0000);
    chk(rd, {tpc_pkg::CMD_SET_PROT_LOOP, tpc_pkg::ERR_NONE});
    run(16'h0002, 64'h0000_0000_000A_0000, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_PAGE_BITS);
    run(16'h0002, 64'h0008_0000_000F_0000, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_PAGE_BITS);
    chk(wrp, 20'hF_FFFE);
    run(16'h0002, 64'h0000_0000_0008_0000, tpc_pkg::CMD_SET_PROT, 0);
    chk({wrp, rdp}, 40'h8_0000_0_0000);
    chk(wrb, blk(20'h8_0000));
    run(16'h0006, 0, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_MULTI_TAG);
    run(16'h0000, 64'h0000_0001_0000_0000, tpc_pkg::CMD_SET_PROT, 0);
    chk({wrp, rdp}, 40'h0_0001_0_0001);
    done("hf");
    busy_base = busy_cnt;
    apb(1'b1, tpc_pkg::ADDR_CMD, 32'h0000_0102);
    repeat (2) @(posedge clk);
    chk(busy_cnt - busy_base, 0);
    apb(1'b0, tpc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, tpc_pkg::ADDR_IRQ_STAT, 3);
    apb(1'b1, tpc_pkg::ADDR_IRQ_MASK, 1);
    chk(irq, 0);
    run(16'h0000, 64'h0000_0001_0000_0000, tpc_pkg::CMD_SET_PROT, 0);
    chk(irq, 1);
    apb(1'b0, tpc_pkg::ADDR_IRQ_STAT, 0);
    chk(rd, 1);
    apb(1'b1, tpc_pkg::ADDR_IRQ_STAT, 1);
    apb(1'b0, tpc_pkg::ADDR_IRQ_STAT, 0);
    chk({irq, rd}, 0);
    run(16'h0006, 0, tpc_pkg::CMD_SET_PROT, tpc_pkg::ERR_MULTI_TAG);
    apb(1'b0, tpc_pkg::ADDR_IRQ_STAT, 0);
    chk({irq, rd}, 33'h1_0000_0003);
    done("irq");
    end_sim();
  end
endmodule
